/* File: logic/tpg_pkg.sv */
// constants and types for the test pulse and timing generator
package tpg_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int TAP_STEP_NS   = 2;
  localparam int PAD_EXTRA_NS  = 500;
  localparam logic [8:0] PAD_EXTRA_CYC =
    9'((PAD_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // ****************************************
  // counters and fields
  // ****************************************
  localparam logic [2:0] VERNIER_LAST = 3'h6;
  localparam logic [3:0] TAP_LAST     = 4'h9;
  localparam int HIST_LEN = 64;
  localparam int SYNC_W   = 16;
  localparam int SY_ORBIT = 0;
  localparam int SY_SGAP  = 1;
  localparam int SY_L1A   = 2;
  localparam int SY_LTIN  = 3;
  localparam int SY_FEOR  = 4;
  localparam int SY_XING  = 8;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [2:0]  VERN_RST  = 3'h0;
  localparam logic [7:0]  XING_RST  = 8'h00;
  localparam logic [15:0] TURN_RST  = 16'h0000;
  localparam logic [15:0] PRESC_RST = 16'h0000;
  // ****************************************
  // types
  // ****************************************
  typedef logic [15:0] turn_t;
  typedef logic [7:0]  xing_t;
  typedef logic [5:0]  delay_t;
  typedef logic [3:0]  tap_t;
  typedef logic [7:0]  gate_t;
  typedef logic [15:0] hit_t;
endpackage : tpg_pkg

/* File: logic/tpg_top.sv */
// test pulse generator, timing delays, local trigger and crossing counters
//
// Notes on behaviour
// (R1) 16-bit turn prescaler: pulse every N turns
// (R2) crossing counter at crossing rate, mod-7 vernier
// (R3) counters place pulse to one beam clock
// (R4) fine placement picks one of ten taps
// (R5) overall placement step is one tap
// (R6) software sets pipeline delay from measurement
// (R7) operator shifts beam and pipeline delays together
// (R8) pad gate about 500 ns beyond wire gate
// (R9) transmit enable is delayed sync gap copy
// (R10) five delays each independently programmable
// (R11) four board ORs form 96-input OR output
// (R12) local trigger delayed to mimic framework latency
// (R13) local trigger input starts acquisition routine
// (R14) crossing and turn counters follow orbit markers
// (R15) each accept fires wire and pad gates when trig_src_local is low
// (R16) crossing advances once per vernier cycle

// ****************************************
// three-stage pin synchroniser
// ****************************************
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // pins and filtered levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_s;
  sync_s st_reg;
  sync_s st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // change counts once stages two and three agree
    st_next.q  = (~(st_reg.s2 ^ st_reg.s3) & st_reg.s3)
               | ((st_reg.s2 ^ st_reg.s3) & st_reg.q);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.q;
endmodule : pin_sync

// ****************************************
// top
// ****************************************
module tpg_top
  import tpg_pkg::*;
(
  // clock and reset
  input  wire logic           sys_clk,
  input  wire logic           rstn,
  // beam timing and framework pins
  input  wire logic           first_crossing,
  input  wire logic           sync_gap_marker,
  input  wire logic           level1_accept,
  input  wire tpg_pkg::xing_t crossing_number_ext,
  // front_end_board trigger ORs and local trigger pins
  input  wire logic [3:0]     fe_trig_or,
  input  wire logic           local_trigger_input,
  // test pulse setup
  input  wire tpg_pkg::turn_t prescale_n,
  input  wire tpg_pkg::xing_t tp_crossing,
  input  wire logic [2:0]     tp_vernier,
  input  wire tpg_pkg::tap_t  tp_tap,
  // five delays and source select
  input  wire tpg_pkg::delay_t orbit_delay,
  input  wire tpg_pkg::delay_t sgap_delay,
  input  wire tpg_pkg::delay_t trig_latency,
  input  wire tpg_pkg::gate_t wire_gate_len,
  input  wire logic [8:0]     pad_gate_len,
  input  wire logic           trig_src_local,
  // hit bits toward first-level trigger
  input  wire tpg_pkg::hit_t  hit_word_in,
  output tpg_pkg::hit_t       hit_word_out,
  output logic                xmit_enable,
  // test pulse
  output logic                test_pulse,
  output tpg_pkg::tap_t       tap_select,
  // transfer gates
  output logic                wire_xfer_gate,
  output logic                pad_xfer_gate,
  // local trigger
  output logic                local_trigger_output,
  output logic                daq_start,
  // counters and check
  output tpg_pkg::xing_t      crossing_count,
  output tpg_pkg::turn_t      turn_count,
  output logic                crossing_mismatch
);
  import tpg_pkg::*;

  typedef struct packed {
    logic [2:0]          vern;
    xing_t               xing;
    turn_t               turn;
    turn_t               presc;
    logic                fire_turn;
    logic [HIST_LEN-1:0] orb_h;
    logic [HIST_LEN-1:0] sgap_h;
    logic [HIST_LEN-1:0] ltrig_h;
    logic                orb_prev;
    logic                l1a_prev;
    logic                ltin_prev;
    logic                or_prev;
    gate_t               wire_c;
    logic [8:0]          pad_c;
    logic                pulse;
    tap_t                tap;
    logic                xmit;
    hit_t                hit;
    logic                wgate;
    logic                pgate;
    logic                lor;
    logic                dstart;
    logic                mism;
  } state_s;

  state_s              st_reg;
  state_s              st_next;
  logic [SYNC_W-1:0]   pins_raw;
  logic [SYNC_W-1:0]   pins;
  logic                or96;
  logic                orb_tick;
  logic                trig;
  logic [8:0]          pad_min;

  assign pins_raw = {crossing_number_ext, fe_trig_or, local_trigger_input,
                     level1_accept, sync_gap_marker, first_crossing};

  pin_sync #(.W(SYNC_W)) u_sync (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .pin_in    (pins_raw),
    .level_out (pins)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next  = st_reg;
    or96     = |pins[SY_FEOR +: 4];                                                 // R11
    orb_tick = st_reg.orb_h[orbit_delay];                                           // R14
    pad_min  = {1'b0, wire_gate_len} + PAD_EXTRA_CYC;                               // R8
    trig     = trig_src_local ? st_reg.ltrig_h[trig_latency]                        // R12
                              : (pins[SY_L1A] & ~st_reg.l1a_prev);

    st_next.orb_prev  = pins[SY_ORBIT];
    st_next.l1a_prev  = pins[SY_L1A];
    st_next.ltin_prev = pins[SY_LTIN];
    st_next.or_prev   = or96;
    // delay histories, each tapped by its own delay value
    st_next.orb_h   = {st_reg.orb_h[HIST_LEN-2:0], pins[SY_ORBIT] & ~st_reg.orb_prev}; // R10
    st_next.sgap_h  = {st_reg.sgap_h[HIST_LEN-2:0], pins[SY_SGAP]};                   // R10
    st_next.ltrig_h = {st_reg.ltrig_h[HIST_LEN-2:0], or96 & ~st_reg.or_prev};         // R10

    // crossing, vernier and turn counters
    if (orb_tick) begin
      st_next.vern = VERN_RST;                                                      // R14
      st_next.xing = XING_RST;
      st_next.turn = st_reg.turn + 16'h0001;
      if (st_reg.presc <= 16'h0001) begin
        st_next.presc     = prescale_n;                                             // R1
        st_next.fire_turn = 1'b1;
      end else begin
        st_next.presc     = st_reg.presc - 16'h0001;
        st_next.fire_turn = 1'b0;
      end
    end else if (st_reg.vern == VERNIER_LAST) begin
      st_next.vern = VERN_RST;                                                      // R2
      st_next.xing = st_reg.xing + 8'h01;                                           // R16
    end else begin
      st_next.vern = st_reg.vern + 3'h1;                                            // R2
    end

    // test pulse: coarse by counters, fine by tap
    st_next.pulse = 1'b0;
    if (st_reg.fire_turn && !orb_tick && st_reg.xing == tp_crossing
        && st_reg.vern == tp_vernier) begin
      st_next.pulse     = 1'b1;                                                     // R3
      st_next.fire_turn = 1'b0;
      st_next.tap       = (tp_tap > TAP_LAST) ? TAP_LAST : tp_tap;                  // R4 R5
    end

    // hit transmit enable gates the hit word
    st_next.xmit = st_reg.sgap_h[sgap_delay];                                       // R9
    st_next.hit  = st_next.xmit ? hit_word_in : 16'h0000;                           // R9

    // transfer gates
    if (trig) begin
      st_next.wire_c = wire_gate_len;                                               // R15
      st_next.pad_c  = (pad_gate_len > pad_min) ? pad_gate_len : pad_min;           // R8
      st_next.mism   = (pins[SY_XING +: 8] != st_reg.xing);                         // R14
    end else begin
      if (st_reg.wire_c != 8'h00) begin
        st_next.wire_c = st_reg.wire_c - 8'h01;
      end
      if (st_reg.pad_c != 9'h000) begin
        st_next.pad_c = st_reg.pad_c - 9'h001;
      end
    end
    st_next.wgate = (st_next.wire_c != 8'h00);                                      // R15
    st_next.pgate = (st_next.pad_c != 9'h000);                                      // R15

    // local trigger paths
    st_next.lor    = or96;                                                          // R11
    st_next.dstart = pins[SY_LTIN] & ~st_reg.ltin_prev;                             // R13
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg       <= '0;
      st_reg.vern  <= VERN_RST;
      st_reg.xing  <= XING_RST;
      st_reg.turn  <= TURN_RST;
      st_reg.presc <= PRESC_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hit_word_out         = st_reg.hit;
  assign xmit_enable          = st_reg.xmit;
  assign test_pulse           = st_reg.pulse;
  assign tap_select           = st_reg.tap;
  assign wire_xfer_gate       = st_reg.wgate;
  assign pad_xfer_gate        = st_reg.pgate;
  assign local_trigger_output = st_reg.lor;
  assign daq_start            = st_reg.dstart;
  assign crossing_count       = st_reg.xing;
  assign turn_count           = st_reg.turn;
  assign crossing_mismatch    = st_reg.mism;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence vern_wrap_s;
    st_reg.vern == VERNIER_LAST && !orb_tick;
  endsequence

  sequence trig_s;
    trig && wire_gate_len != 8'h00;
  endsequence

  a_vernier_wrap: assert property (vern_wrap_s |=> st_reg.vern == 3'h0) // R2
    else $error("vernier did not wrap after seven");
  a_vernier_range: assert property (st_reg.vern <= VERNIER_LAST) // R2
    else $error("vernier out of range");
  a_xing_once: assert property (!orb_tick && st_reg.vern != VERNIER_LAST |=> $stable(st_reg.xing)) // R16
    else $error("crossing moved mid vernier cycle");
  a_xing_step: assert property (vern_wrap_s |=> st_reg.xing == $past(st_reg.xing) + 8'h01) // R16
    else $error("crossing did not step at wrap");
  a_turn_step: assert property (orb_tick |=> turn_count == $past(turn_count) + 16'h0001) // R14
    else $error("turn counter missed orbit marker");
  a_pulse_place: assert property (test_pulse |-> $past(st_reg.vern) == $past(tp_vernier)) // R3
    else $error("test pulse off vernier slot");
  a_tap_range: assert property (tap_select <= TAP_LAST) // R4
    else $error("tap select beyond last tap");
  a_wire_gate: assert property (trig_s |=> wire_xfer_gate && pad_xfer_gate) // R15
    else $error("gates not started by accept");
  a_pad_longer: assert property ($fell(wire_xfer_gate) && !$past(trig) |-> pad_xfer_gate [*5]) // R8
    else $error("pad gate not longer than wire gate");
  a_hit_gated: assert property (!xmit_enable |-> hit_word_out == 16'h0000) // R9
    else $error("hit bits sent outside enable");
  a_local_or: assert property (##1 local_trigger_output == $past(|pins[SY_FEOR +: 4])) // R11
    else $error("local trigger output wrong");
  a_daq_start: assert property (daq_start |-> $past(pins[SY_LTIN]) && !$past(pins[SY_LTIN], 2)) // R13
    else $error("daq start without input edge");
endmodule : tpg_top

/* File: verif/far_side_model.sv */
// far side model: framework timing stream and accept pulses
module far_side_model #(
  parameter int TURN_CYC = 70,
  parameter int SGAP_CYC = 6
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // accept request from bench
  input  wire logic accept_req,
  // timing pins
  output logic      first_crossing,
  output logic      sync_gap_marker,
  output logic      level1_accept
);
  timeunit 1ns;
  timeprecision 1ns;
  int   phase;
  int   acc_left;
  logic req;
  logic rst_seen;
  // ****************************************
  // orbit, sync gap and accept generation
  // ****************************************
  initial begin
    first_crossing = 1'b0;
    sync_gap_marker = 1'b0;
    level1_accept = 1'b0;
    phase = 0;
    acc_left = 0;
    forever begin
      @(posedge sys_clk);
      req = accept_req;
      // reset taken at the edge, clear of the bench's release time
      rst_seen = !rstn;
      #10;
      phase = (rst_seen || phase == TURN_CYC - 1) ? 0 : phase + 1;
      first_crossing = (phase < 2);
      sync_gap_marker = (phase >= TURN_CYC - SGAP_CYC);
      if (req) begin
        acc_left = 3;
      end
      level1_accept = (acc_left > 0);
      if (acc_left > 0) begin
        acc_left--;
      end
    end
  end
endmodule : far_side_model

/* File: verif/testbench.sv */
// self-checking bench for the test pulse and timing generator
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tpg_pkg::*;
  localparam int TURN_CYC = 70;
  localparam int SGAP_CYC = 6;
  logic        sys_clk, rstn, accept_req, first_crossing, sync_gap_marker, level1_accept;
  logic        local_trigger_input, trig_src_local, xmit_enable, test_pulse, wire_xfer_gate;
  logic        pad_xfer_gate, local_trigger_output, daq_start, crossing_mismatch;
  logic [3:0]  fe_trig_or;
  logic [2:0]  tp_vernier;
  logic [8:0]  pad_gate_len;
  xing_t       crossing_number_ext, tp_crossing, crossing_count;
  turn_t       prescale_n, turn_count;
  tap_t        tp_tap, tap_select;
  delay_t      orbit_delay, sgap_delay, trig_latency;
  gate_t       wire_gate_len;
  hit_t        hit_word_in, hit_word_out;
  int          error_cnt, total_checks;

  far_side_model #(.TURN_CYC(TURN_CYC), .SGAP_CYC(SGAP_CYC)) far (.sys_clk(sys_clk), .rstn(rstn),
    .accept_req(accept_req), .first_crossing(first_crossing), .sync_gap_marker(sync_gap_marker),
    .level1_accept(level1_accept));

  tpg_top DUT (.sys_clk(sys_clk), .rstn(rstn), .first_crossing(first_crossing),
    .sync_gap_marker(sync_gap_marker), .level1_accept(level1_accept),
    .crossing_number_ext(crossing_number_ext), .fe_trig_or(fe_trig_or),
    .local_trigger_input(local_trigger_input), .prescale_n(prescale_n), .tp_crossing(tp_crossing),
    .tp_vernier(tp_vernier), .tp_tap(tp_tap), .orbit_delay(orbit_delay), .sgap_delay(sgap_delay),
    .trig_latency(trig_latency), .wire_gate_len(wire_gate_len), .pad_gate_len(pad_gate_len),
    .trig_src_local(trig_src_local), .hit_word_in(hit_word_in), .hit_word_out(hit_word_out),
    .xmit_enable(xmit_enable), .test_pulse(test_pulse), .tap_select(tap_select),
    .wire_xfer_gate(wire_xfer_gate), .pad_xfer_gate(pad_xfer_gate),
    .local_trigger_output(local_trigger_output), .daq_start(daq_start),
    .crossing_count(crossing_count), .turn_count(turn_count), .crossing_mismatch(crossing_mismatch));
  // ****************************************
  // helpers
  // ****************************************
  task automatic conclude();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask : cyc

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : chk

  function automatic logic sig(int i);
    case (i)
      0: return wire_xfer_gate;
      1: return pad_xfer_gate;
      2: return test_pulse;
      3: return daq_start;
      4: return xmit_enable;
      default: return local_trigger_output;
    endcase
  endfunction : sig

  task automatic wait_hi(int i, int lim);
    int n;
    n = 0;
    while (sig(i) !== 1'b1) begin
      if (n == lim) begin
        $display("mismatch wait_%0d expected 1 seen timeout", i);
        error_cnt++;
        conclude();
      end
      n++;
      cyc(1);
    end
  endtask : wait_hi

  task automatic high_len(int i, output int len);
    len = 0;
    while (sig(i) === 1'b1 && len < 600) begin
      len++;
      cyc(1);
    end
    if (len == 600) begin
      $display("mismatch high_%0d expected low seen stuck", i);
      error_cnt++;
    end
  endtask : high_len
  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_crossing();
    xing_t c;
    xing_t top;
    int    n;
    turn_t t0;
    top = 8'h00;
    t0 = turn_count;
    for (int k = 0; k < TURN_CYC; k++) begin
      if (crossing_count > top) top = crossing_count;
      cyc(1);
    end
    chk("crossing_max", 16'h0009, 16'(top));
    chk("turn_step", 16'h0001, turn_count - t0);
    for (int k = 0; k < 2; k++) begin
      c = crossing_count;
      n = 0;
      while (crossing_count === c && n < 20) begin
        n++;
        cyc(1);
      end
    end
    chk("crossing_period", 16'h0007, 16'(n));
  endtask : test_crossing

  task automatic test_pulse_gen();
    int n;
    wait_hi(2, 3 * TURN_CYC);
    chk("tap_select", 16'h0007, 16'(tap_select));
    cyc(1);
    chk("pulse_width", 16'h0000, 16'(test_pulse));
    n = 1;
    while (test_pulse !== 1'b1 && n < 400) begin
      n++;
      cyc(1);
    end
    chk("pulse_spacing", 16'(2 * TURN_CYC), 16'(n));
  endtask : test_pulse_gen

  task automatic test_gates();
    int n;
    int m;
    crossing_number_ext = 8'hff;
    for (int k = 0; k < 2; k++) begin
      pad_gate_len = k ? 9'h014 : 9'h003;
      accept_req = 1'b1;
      cyc(1);
      accept_req = 1'b0;
      wait_hi(0, 20);
      chk("pad_start", 16'h0001, 16'(pad_xfer_gate));
      chk("crossing_mismatch", 16'h0001, 16'(crossing_mismatch));
      high_len(0, n);
      chk("wire_len", 16'h000a, 16'(n));
      high_len(1, m);
      chk("pad_len", k ? 16'h0014 : 16'h000f, 16'(n + m));
      cyc(5);
    end
  endtask : test_gates

  task automatic test_xmit();
    int n;
    int e;
    for (int j = 0; j < 2; j++) begin
      if (j == 1) begin
        // beam and pipeline side moved by the same amount
        orbit_delay = orbit_delay + 6'h04;
        sgap_delay = sgap_delay + 6'h04;
        cyc(TURN_CYC);
      end
      // skip a window already under way
      high_len(4, n);
      wait_hi(4, 2 * TURN_CYC);
      e = (TURN_CYC - SGAP_CYC + int'(sgap_delay) - int'(orbit_delay)) / 7;
      chk("xmit_crossing", 16'(e), 16'(crossing_count));
      n = 0;
      while (xmit_enable === 1'b1 && n < 100) begin
        chk("hit_word_out", hit_word_in, hit_word_out);
        n++;
        cyc(1);
      end
      chk("xmit_len", 16'(SGAP_CYC), 16'(n));
      chk("hit_word_idle", 16'h0000, hit_word_out);
    end
  endtask : test_xmit

  task automatic test_local();
    int n;
    trig_src_local = 1'b1;
    fe_trig_or = 4'b0100;
    wait_hi(5, 10);
    chk("local_out", 16'h0001, 16'(local_trigger_output));
    n = 0;
    while (wire_xfer_gate !== 1'b1 && n < 90) begin
      n++;
      cyc(1);
    end
    chk("local_latency", 16'(trig_latency) + 16'h0001, 16'(n));
    fe_trig_or = 4'b0000;
    cyc(30);
    chk("local_out_low", 16'h0000, 16'(local_trigger_output));
    trig_src_local = 1'b0;
    local_trigger_input = 1'b1;
    wait_hi(3, 10);
    cyc(1);
    chk("daq_start_width", 16'h0000, 16'(daq_start));
    local_trigger_input = 1'b0;
  endtask : test_local
  // ****************************************
  // clock, reset and sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    error_cnt = 0;
    total_checks = 0;
    rstn = 1'b0;
    accept_req = 1'b0;
    fe_trig_or = 4'b0000;
    local_trigger_input = 1'b0;
    trig_src_local = 1'b0;
    crossing_number_ext = 8'h00;
    prescale_n = 16'h0002;
    tp_crossing = 8'h03;
    tp_vernier = 3'h2;
    tp_tap = 4'h7;
    orbit_delay = 6'h02;
    sgap_delay = 6'h03;
    trig_latency = 6'h08;
    wire_gate_len = 8'h0a;
    pad_gate_len = 9'h003;
    hit_word_in = 16'ha5c3;
    repeat (5) @(posedge sys_clk);
    #10;
    rstn = 1'b1;
    cyc(2 * TURN_CYC);
    test_crossing();
    test_pulse_gen();
    test_gates();
    test_xmit();
    test_local();
    conclude();
  end
endmodule : testbench
